// [logic/jtag_debug_access_port.sv]
// Overview of operation
// RL1: test data input is taken on each rising test clock edge while shifting ir or dr.
// RL2: test mode select is taken on each rising test clock edge and steps the controller.
// RL3: test data output changes only on falling test clock edges.
// RL4: test data output is driven only in shift-ir and shift-dr, else released.
// RL5: the test reset input forces test-logic-reset at on_chip_debug_module, without a test clock edge.
// RL6: the host asserts test reset after power-up so the test logic starts initialized.
// RL7: an external debug request makes the core finish, save state, enter debug and wait.
// RL8: debug entry from request or breakpoint pulls the debug event pin for three cycles.
// RL9: the debug event pin is open drain: only pulled low, otherwise released.
// RL10: all other debug access goes through the four-wire test port.
// RL11: the controller is the full sixteen-state test access port state machine.
`timescale 1ns/10ps
`default_nettype none
module jtag_debug_access_port (
  // clock and reset
  input  wire logic                           clock,
  input  wire logic                           rst_b,
  // test access port pins
  input  wire logic                           tck,
  input  wire logic                           tms,
  input  wire logic                           tdi,
  input  wire logic                           trst_b,
  output logic                                tdo,
  output logic                                tdo_oe,
  // debug event pin, open drain
  input  wire logic                           debug_event_pin_in,
  output logic                                debug_event_pin_out,
  output logic                                debug_event_pin_oe,
  // core handshake
  output logic                                debug_req,
  input  wire logic                           core_instr_done,
  input  wire logic                           core_breakpoint,
  output logic                                core_in_debug,
  // debug command words to the core
  output logic                                cmd_valid,
  input  wire logic                           cmd_ready,
  output logic [dbg_tap_pkg::FIFO_W-1:0]      cmd_data,
  output logic                                cmd_overflow
);
  import dbg_tap_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0]  tck_s_ff;
  logic [1:0]  tms_s_ff;
  logic [1:0]  tdi_s_ff;
  logic [1:0]  trst_s_ff;
  logic [1:0]  de_s_ff;
  logic        tck_rise;
  logic        tck_fall;
  logic        trst_on;

  // two stages before use, third for edge detection
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tck_s_ff  <= '0;
      tms_s_ff  <= 2'h3;
      tdi_s_ff  <= 2'h3;
      trst_s_ff <= '0;
      de_s_ff   <= 2'h3;
    end else begin
      tck_s_ff  <= {tck_s_ff[1:0], tck};
      tms_s_ff  <= {tms_s_ff[0], tms};
      tdi_s_ff  <= {tdi_s_ff[0], tdi};
      trst_s_ff <= {trst_s_ff[0], trst_b};
      de_s_ff   <= {de_s_ff[0], debug_event_pin_in};
    end
  end

  assign tck_rise = tck_s_ff[1] && !tck_s_ff[2];
  assign tck_fall = !tck_s_ff[1] && tck_s_ff[2];
  // test reset acts from the synchronised pin only, no test clock edge needed
  assign trst_on  = !trst_s_ff[1];

  // ************************************************************
  // tap controller
  // ************************************************************
  tap_state_e st_ff;
  tap_state_e nxt_st;

  // standard sixteen-state next-state table
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff) // see RL11
      st_reset:    nxt_st = tms_s_ff[1] ? st_reset    : st_idle;
      st_idle:     nxt_st = tms_s_ff[1] ? st_sel_dr   : st_idle;
      st_sel_dr:   nxt_st = tms_s_ff[1] ? st_sel_ir   : st_cap_dr;
      st_cap_dr:   nxt_st = tms_s_ff[1] ? st_exit1_dr : st_shift_dr;
      st_shift_dr: nxt_st = tms_s_ff[1] ? st_exit1_dr : st_shift_dr;
      st_exit1_dr: nxt_st = tms_s_ff[1] ? st_upd_dr   : st_pause_dr;
      st_pause_dr: nxt_st = tms_s_ff[1] ? st_exit2_dr : st_pause_dr;
      st_exit2_dr: nxt_st = tms_s_ff[1] ? st_upd_dr   : st_shift_dr;
      st_upd_dr:   nxt_st = tms_s_ff[1] ? st_sel_dr   : st_idle;
      st_sel_ir:   nxt_st = tms_s_ff[1] ? st_reset    : st_cap_ir;
      st_cap_ir:   nxt_st = tms_s_ff[1] ? st_exit1_ir : st_shift_ir;
      st_shift_ir: nxt_st = tms_s_ff[1] ? st_exit1_ir : st_shift_ir;
      st_exit1_ir: nxt_st = tms_s_ff[1] ? st_upd_ir   : st_pause_ir;
      st_pause_ir: nxt_st = tms_s_ff[1] ? st_exit2_ir : st_pause_ir;
      st_exit2_ir: nxt_st = tms_s_ff[1] ? st_upd_ir   : st_shift_ir;
      st_upd_ir:   nxt_st = tms_s_ff[1] ? st_sel_dr   : st_idle;
    endcase
  end

  // state steps on rising test clock, test reset overrides
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= st_reset;
    end else if (trst_on) begin
      st_ff <= st_reset; // see RL5
    end else if (tck_rise) begin
      st_ff <= nxt_st; // see RL2
    end
  end

  // ************************************************************
  // instruction and data shift paths
  // ************************************************************
  logic [IR_W-1:0] ir_sh_ff;
  logic [IR_W-1:0] ir_ff;
  logic [DR_W-1:0] dr_sh_ff;
  logic            byp_ff;
  logic            in_shift;
  logic            fifo_ready;
  logic            push_ff;
  logic [DR_W-1:0] push_data_ff;

  assign in_shift = (st_ff == st_shift_ir) || (st_ff == st_shift_dr);

  // instruction register, capture, shift, update
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ir_sh_ff <= '0;
      ir_ff    <= IR_RESET;
    end else if (trst_on) begin
      ir_ff <= IR_RESET; // see RL5
    end else if (tck_rise) begin
      unique case (st_ff)
        st_cap_ir:   ir_sh_ff <= IR_CAPTURE;
        st_shift_ir: ir_sh_ff <= {tdi_s_ff[1], ir_sh_ff[IR_W-1:1]}; // see RL1
        st_upd_ir:   ir_ff    <= ir_sh_ff;
        st_reset:    ir_ff    <= IR_RESET;
        default:     ir_ff    <= ir_ff;
      endcase
    end
  end

  // data registers; debug data words reach the core only via the port
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dr_sh_ff     <= '0;
      byp_ff       <= 1'b0;
      push_ff      <= 1'b0;
      push_data_ff <= '0;
    end else begin
      if (fifo_ready) begin
        push_ff <= 1'b0;
      end
      if (tck_rise && !trst_on) begin
        unique case (st_ff)
          st_cap_dr: begin
            dr_sh_ff <= '0;
            byp_ff   <= 1'b0;
          end
          st_shift_dr: begin
            dr_sh_ff <= {tdi_s_ff[1], dr_sh_ff[DR_W-1:1]}; // see RL1
            byp_ff   <= tdi_s_ff[1];
          end
          st_upd_dr: begin
            if (ir_ff == IR_DBG_DATA) begin
              push_ff      <= 1'b1; // see RL10
              push_data_ff <= dr_sh_ff;
            end
          end
          default: byp_ff <= byp_ff;
        endcase
      end
    end
  end

  // ************************************************************
  // test data output, falling edge only
  // ************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (trst_on) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= in_shift; // see RL4
      unique case (st_ff)
        st_shift_ir: tdo <= ir_sh_ff[0]; // see RL3
        st_shift_dr: tdo <= (ir_ff == IR_BYPASS) ? byp_ff : dr_sh_ff[0]; // see RL3
        default:     tdo <= tdo;
      endcase
    end
  end

  // ************************************************************
  // debug entry and event pin
  // ************************************************************
  logic       req_pend_ff;
  logic [1:0] ack_cnt_ff;
  logic       ack_on_ff;
  logic       enter;

  assign enter = !core_in_debug && ((req_pend_ff && core_instr_done) || core_breakpoint);

  // request from pin or instruction waits for the core to finish
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      req_pend_ff   <= 1'b0;
      core_in_debug <= 1'b0;
      debug_req     <= 1'b0;
    end else begin
      if (enter) begin
        core_in_debug <= 1'b1; // see RL7
        req_pend_ff   <= 1'b0;
      end else if (!core_in_debug && !ack_on_ff &&
                   (!de_s_ff[1] || (ir_ff == IR_DBG_REQ))) begin
        req_pend_ff <= 1'b1; // see RL7
      end
      if (trst_on) begin
        core_in_debug <= 1'b0;
      end
      debug_req <= req_pend_ff && !enter;
    end
  end

  // three-cycle low pulse, never driven high
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_cnt_ff          <= '0;
      ack_on_ff           <= 1'b0;
      debug_event_pin_oe  <= 1'b0;
      debug_event_pin_out <= 1'b0;
    end else begin
      debug_event_pin_out <= 1'b0; // see RL9
      if (enter) begin
        ack_on_ff          <= 1'b1;
        ack_cnt_ff         <= '0;
        debug_event_pin_oe <= 1'b1; // see RL8
      end else if (ack_on_ff) begin
        if (ack_cnt_ff == ACK_CNT_LAST) begin
          ack_on_ff          <= 1'b0;
          debug_event_pin_oe <= 1'b0; // see RL8
        end else begin
          ack_cnt_ff <= ack_cnt_ff + 1'b1;
        end
      end
    end
  end

  a_ack_width: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(debug_event_pin_oe) |-> debug_event_pin_oe[*3] ##1 !debug_event_pin_oe) // see RL8
    else $error("debug event pulse not three cycles");
  a_pin_low: assert property (@(posedge clock) disable iff (!rst_b)
    debug_event_pin_oe |-> !debug_event_pin_out) // see RL9
    else $error("debug event pin driven high");
  a_tdo_shift: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(tdo_oe) |-> $past(in_shift)) // see RL4
    else $error("tdo enabled outside shift");
  a_tdo_edge: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(tdo) |-> $past(tck_fall)) // see RL3
    else $error("tdo changed off falling edge");
  a_trst_now: assert property (@(posedge clock) disable iff (!rst_b)
    trst_on |=> st_ff == st_reset) // see RL5
    else $error("test reset did not reset controller");
  a_tms_step: assert property (@(posedge clock) disable iff (!rst_b)
    !tck_rise && !trst_on |=> $stable(st_ff)) // see RL2
    else $error("state moved without test clock");
  a_dbg_enter: assert property (@(posedge clock) disable iff (!rst_b)
    enter |=> core_in_debug && debug_event_pin_oe) // see RL7
    else $error("debug entry missing");
  a_shift_in: assert property (@(posedge clock) disable iff (!rst_b)
    tck_rise && !trst_on && st_ff == st_shift_dr |=> dr_sh_ff[DR_W-1] == $past(tdi_s_ff[1])) // see RL1
    else $error("tdi not shifted in");

  // ************************************************************
  // command word buffer
  // ************************************************************
  dbg_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_cmd_fifo (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (push_ff),
    .in_ready  (fifo_ready),
    .in_data   (push_data_ff),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (cmd_data)
  );

  // sticky flag when an update finds the buffer still busy
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd_overflow <= 1'b0;
    end else if (tck_rise && st_ff == st_upd_dr && push_ff && !fifo_ready) begin
      cmd_overflow <= 1'b1;
    end
  end
endmodule : jtag_debug_access_port
`default_nettype wire

// [logic/dbg_tap_pkg.sv]
package dbg_tap_pkg;
  // ************************************************************
  // tap states, widths and debug pulse timing
  // ************************************************************
  typedef enum logic [3:0] {
    st_reset, st_idle, st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr,
    st_exit2_dr, st_upd_dr, st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir,
    st_pause_ir, st_exit2_ir, st_upd_ir
  } tap_state_e;

  localparam int          IR_W         = 4;
  localparam int          DR_W         = 32;
  localparam int          FIFO_W       = 32;
  localparam int          FIFO_D       = 32;
  localparam logic [3:0]  IR_RESET     = 4'h1;
  localparam logic [3:0]  IR_CAPTURE   = 4'h1;
  localparam logic [3:0]  IR_BYPASS    = 4'hf;
  localparam logic [3:0]  IR_DBG_REQ   = 4'h7;
  localparam logic [3:0]  IR_DBG_DATA  = 4'h8;
  localparam int          ACK_CYCLES   = 3;
  localparam logic [1:0]  ACK_CNT_LAST = 2'(ACK_CYCLES - 1);
endpackage : dbg_tap_pkg

// [logic/dbg_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module dbg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule : dbg_fifo
`default_nettype wire

// [test/jtag_host.sv]
`timescale 1ns/10ps
`default_nettype none
module jtag_host (
  // pacing clock
  input  wire logic clock,
  // link pins driven by the host
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_b,
  // link pins seen by the host
  input  wire logic tdo_wire,
  input  wire logic tdo_oe
);
  // ************************************************************
  // serial host model
  // ************************************************************
  logic [31:0] got;
  logic        oe_all;
  // tck stands low outside frames, released pins sit at pull-up level
  initial begin
    tck    = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b1;
    trst_b = 1'b0;
  end
  // drive or release test reset
  task automatic set_trst(input logic lvl);
    trst_b = lvl;
  endtask : set_trst
  // one bit: change after fall, sample tdo just before rise
  task automatic step(input logic m, input logic d, input int idx);
    tms = m;
    tdi = d;
    repeat (10) @(negedge clock);
    if (idx >= 0) begin
      got[idx] = tdo_wire;
      oe_all   = oe_all & tdo_oe;
    end
    tck = 1'b1;
    repeat (10) @(negedge clock);
    tck = 1'b0;
  endtask : step
  // walk into shift-dr and stop the clock there
  task automatic to_shift;
    step(1'b0, 1'b1, -1);
    step(1'b1, 1'b1, -1);
    step(1'b0, 1'b1, -1);
    step(1'b0, 1'b1, -1);
  endtask : to_shift
  // whole ir or dr scan, lsb first, ending in idle
  task automatic scan(input logic [31:0] w, input int n, input logic ir);
    int i;
    got    = '0;
    oe_all = 1'b1;
    step(1'b0, 1'b1, -1);
    step(1'b1, 1'b1, -1);
    if (ir) step(1'b1, 1'b1, -1);
    step(1'b0, 1'b1, -1);
    step(1'b0, 1'b1, -1);
    for (i = 0; i < n; i++) step(i == n - 1, w[i], i);
    step(1'b1, 1'b1, -1);
    step(1'b0, 1'b1, -1);
    tms = 1'b1;
    tdi = 1'b1;
  endtask : scan
endmodule : jtag_host
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dbg_tap_pkg::*;
  // ************************************************************
  // signals and instances
  // ************************************************************
  logic        clock, rst_b, de_req, core_instr_done, core_breakpoint;
  logic        cmd_ready, ready_mode, tck, tms, tdi, trst_b, tdo, tdo_oe;
  logic        tdo_wire, de_wire, debug_event_pin_out, debug_event_pin_oe;
  logic        debug_req, core_in_debug, cmd_valid, cmd_overflow;
  logic [31:0] cmd_data, v;
  logic [31:0] q[$];
  int          failures, total_checks, i, k, n;
  // released tdo shows the inverse, event pin has a pull-up
  assign tdo_wire = tdo_oe ? tdo : ~tdo;
  assign de_wire  = !(debug_event_pin_oe && !debug_event_pin_out) && !de_req;
  always #4 clock = ~clock;
  jtag_debug_access_port i_jtag_debug_access_port (
    .clock(clock), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b),
    .tdo(tdo), .tdo_oe(tdo_oe), .debug_event_pin_in(de_wire),
    .debug_event_pin_out(debug_event_pin_out), .debug_event_pin_oe(debug_event_pin_oe),
    .debug_req(debug_req), .core_instr_done(core_instr_done),
    .core_breakpoint(core_breakpoint), .core_in_debug(core_in_debug),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
    .cmd_overflow(cmd_overflow));
  jtag_host i_jtag_host (
    .clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b),
    .tdo_wire(tdo_wire), .tdo_oe(tdo_oe));
  // ************************************************************
  // checking helpers
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check
  task automatic close_out;
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic wait_hi(ref logic s, input int bound);
    int j;
    for (j = 0; j < bound && s !== 1'b1; j++) @(negedge clock);
    check(s, 1'b1, "wait bound");
    if (s !== 1'b1) close_out();
  endtask : wait_hi
  // length of the event pin pull in clocks
  task automatic pulse(output int c);
    c = 0;
    wait_hi(debug_event_pin_oe, 400);
    while (debug_event_pin_oe === 1'b1 && c < 10) begin
      c++;
      @(negedge clock);
    end
  endtask : pulse
  function automatic logic [31:0] byp_exp(input logic [31:0] w);
    return {w[30:0], 1'b0};
  endfunction : byp_exp
  task automatic push(input logic [31:0] w, input logic keep);
    if (keep) q.push_back(w);
    i_jtag_host.scan(w, DR_W, 1'b0);
  endtask : push
  task automatic drain;
    int j;
    for (j = 0; j < 3000 && q.size() > 0; j++) @(negedge clock);
    repeat (3) @(negedge clock);
    check(q.size(), 0, "drain");
    if (q.size() > 0) close_out();
    check(cmd_valid, 1'b0, "empty");
  endtask : drain
  // drain side: pick ready, then score the handshake of the coming rising edge
  always @(negedge clock) begin
    cmd_ready = ready_mode & 1'($urandom);
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
      if (q.size() == 0) check(cmd_valid, 1'b0, "extra word");
      else check(cmd_data, q.pop_front(), "word order");
    end
  end
  // tdo may only move while the link clock is low
  always @(tdo) if (rst_b === 1'b1 && tdo_oe === 1'b1) check(tck, 1'b0, "tdo edge");
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {clock, rst_b, de_req, core_instr_done, core_breakpoint, ready_mode} = '0;
    failures     = 0;
    total_checks = 0;
    void'($urandom(32'h9546));
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    repeat (3) @(negedge clock);
    i_jtag_host.set_trst(1'b1);
    check({tdo_oe, debug_event_pin_oe, debug_req, core_in_debug, cmd_valid, cmd_overflow},
          0, "reset state");
    // test reset in mid-shift with the link clock still
    i_jtag_host.to_shift();
    repeat (12) @(negedge clock);
    check(tdo_oe, 1'b1, "shift drive");
    i_jtag_host.set_trst(1'b0);
    repeat (3) @(negedge clock);
    check(tdo_oe, 1'b0, "test reset");
    i_jtag_host.set_trst(1'b1);
    // bypass: capture code, then one bit of delay
    i_jtag_host.scan(32'(IR_BYPASS), IR_W, 1'b1);
    check(i_jtag_host.got, 32'(IR_CAPTURE), "ir capture");
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'haaaa5555 : $urandom;
      i_jtag_host.scan(v, DR_W, 1'b0);
      check(i_jtag_host.got, byp_exp(v), "bypass");
      check(i_jtag_host.oe_all, 1'b1, "shift drive");
      repeat (5) @(negedge clock);
      check(tdo_oe, 1'b0, "idle release");
    end
    // data words in order under random stalls, then fill past full
    ready_mode = 1'b1;
    i_jtag_host.scan(32'(IR_DBG_DATA), IR_W, 1'b1);
    for (i = 0; i < 8; i++) push((i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $urandom, 1'b1);
    drain();
    ready_mode = 1'b0;
    for (i = 0; i < FIFO_D; i++) push($urandom, 1'b1);
    check(cmd_overflow, 1'b0, "early overflow");
    push($urandom, 1'b0);
    check(cmd_overflow, 1'b0, "pending word");
    push($urandom, 1'b1);
    check(cmd_overflow, 1'b1, "overflow");
    ready_mode = 1'b1;
    drain();
    // debug entry by pin, breakpoint and serial request
    for (k = 0; k < 3; k++) begin
      fork
        begin
          case (k)
            0: begin
              de_req = 1'b1;
              wait_hi(debug_req, 20);
              de_req = 1'b0;
              repeat (5) @(negedge clock);
              check({core_in_debug, debug_event_pin_oe}, 0, "early entry");
              core_instr_done = 1'b1;
            end
            1: begin
              core_breakpoint = 1'b1;
              @(negedge clock);
              core_breakpoint = 1'b0;
            end
            default: i_jtag_host.scan(32'(IR_DBG_REQ), IR_W, 1'b1);
          endcase
        end
        pulse(n);
      join
      check(n, ACK_CYCLES, "ack length");
      check({core_in_debug, debug_event_pin_out, de_wire}, 3'b101, "entry");
      de_req          = 1'b1;
      core_breakpoint = 1'b1;
      @(negedge clock);
      core_breakpoint = 1'b0;
      for (i = 0; i < 20; i++) begin
        check(debug_event_pin_oe, 1'b0, "second ack");
        @(negedge clock);
      end
      de_req = 1'b0;
      i_jtag_host.set_trst(1'b0);
      repeat (4) @(negedge clock);
      i_jtag_host.set_trst(1'b1);
      repeat (4) @(negedge clock);
      check({core_in_debug, debug_req}, 0, "debug exit");
    end
    close_out();
  end
endmodule : tb_top
`default_nettype wire
